/* rtl/uart_consts.vh */
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
// register offsets on the plain register port
`define A_DATA 4'h0
`define A_IEN 4'h1
`define A_IID 4'h2
`define A_LCTL 4'h3
`define A_MCTL 4'h4
`define A_LSR 4'h5
`define A_DLL 4'h6
`define A_DIVH 4'h7
`define A_LPDIVL 4'h8
`define A_LPDIVH 4'h9
// line control fields
`define LCTL_PEN 3
`define LCTL_EPS 4
`define LCTL_BRK 6
`define LCTL_STB 2
// modem control fields
`define MCTL_IR 6
`define MCTL_LPWR 7
// interrupt enable fields
`define IEN_RDA 0
`define IEN_THRE 1
`define IEN_LINE 2
// interrupt identification codes
`define IID_NONE 4'h1
`define IID_LINE 4'h6
`define IID_RDA 4'h4
`define IID_CTO 4'hC
`define IID_THRE 4'h2
// reset values
`define LCTL_RST 8'h03
`define REG_RST 8'h00
`define DIV_RST 16'h0000
// timing counts in baud ticks and clocks
`define BIT_TICKS 4'hF
`define MID_TICKS 4'h7
`define HALF_STOP 4'h7
`define SIR_PULSE 4'h3
`define SETTLE_CYC 4'h8
`define TO_CHARS 4
`endif

/* rtl/baud_gen.v */
`include "uart_consts.vh"
module baud_gen #(
   parameter DW = 16
) (
   input wire mclk_in,
   input wire rst_in,
   input wire [DW-1:0] div_in,
   input wire [DW-1:0] lp_div_in,
   output reg tick_out,
   output reg lp_tick_out,
   output reg baudout_n_out
);
   reg [DW-1:0] cnt_reg;
   reg [DW-1:0] lp_cnt_reg;
   wire hit = (div_in != {DW{1'b0}}) && (cnt_reg >= div_in - 1'b1);
   wire lp_hit = (lp_div_in != {DW{1'b0}}) && (lp_cnt_reg >= lp_div_in - 1'b1);

   // divide the clock by the divisor latch; zero divisor stops the baud clock
   always @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_reg <= {DW{1'b0}};
         lp_cnt_reg <= {DW{1'b0}};
         tick_out <= 1'b0;
         lp_tick_out <= 1'b0;
         baudout_n_out <= 1'b1;
      end else begin
         cnt_reg <= hit ? {DW{1'b0}} : cnt_reg + 1'b1;
         lp_cnt_reg <= lp_hit ? {DW{1'b0}} : lp_cnt_reg + 1'b1;
         tick_out <= hit;
         lp_tick_out <= lp_hit;
         baudout_n_out <= ~hit;
      end
   end
endmodule // baud_gen

/* rtl/sir_codec.v */
`include "uart_consts.vh"
module sir_codec (
   input wire mclk_in,
   input wire rst_in,
   input wire tick_in,
   input wire lp_tick_in,
   input wire lp_mode_in,
   input wire tx_active_in,
   input wire tx_bit_in,
   input wire [3:0] tx_phase_in,
   input wire ir_rx_in,
   output reg ir_tx_n_out,
   output reg rx_line_out
);
   reg [4:0] stretch_reg;
   wire detect = ~ir_rx_in & (lp_mode_in ? lp_tick_in : tick_in);

   // a zero bit becomes a low pulse of three sixteenths of a bit
   always @(posedge mclk_in) begin
      if (rst_in) begin
         ir_tx_n_out <= 1'b1;
      end else begin
         ir_tx_n_out <= ~(tx_active_in & ~tx_bit_in & (tx_phase_in < `SIR_PULSE));
      end
   end

   // a received low pulse is stretched into one zero bit on the line
   always @(posedge mclk_in) begin
      if (rst_in) begin
         stretch_reg <= 5'h00;
         rx_line_out <= 1'b1;
      end else begin
         if (detect) begin
            stretch_reg <= 5'h10;
         end else if (tick_in && stretch_reg != 5'h00) begin
            stretch_reg <= stretch_reg - 5'h01;
         end
         rx_line_out <= ~detect & (stretch_reg == 5'h00);
      end
   end
endmodule // sir_codec

/* rtl/uart_core.v */
// Added by the designer: strobed register access and the register offsets.
`include "uart_consts.vh"
module uart_core #(
   parameter SIR_SUPPORT = 1,
   parameter DW = 16
) (
   input wire mclk_in,
   input wire rst_in,
   input wire [3:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   input wire serial_rx_in,
   output reg serial_tx_out,
   input wire ir_rx_in,
   output reg ir_tx_n_out,
   output wire baudout_n_out,
   output reg int_out
);
   localparam T_IDLE = 3'd0, T_START = 3'd1, T_DATA = 3'd2, T_PAR = 3'd3;
   localparam T_STOP = 3'd4, T_STOP2 = 3'd5;
   localparam R_IDLE = 3'd0, R_START = 3'd1, R_DATA = 3'd2, R_PAR = 3'd3, R_STOP = 3'd4;

   reg [7:0] interrupt_enable_reg, line_control_reg, modem_control_reg, thr_reg, rbr_reg;
   reg [DW-1:0] div_reg, lpdiv_reg, a_div_reg, a_lpdiv_reg;
   reg [7:0] a_lctl_reg, a_mctl_reg;
   reg [3:0] settle_reg;
   reg pend_reg;
   reg thr_empty_reg, thre_int_reg, dr_reg, oe_reg, pe_reg, fe_reg, bi_reg, cto_reg;
   reg [2:0] tx_st_reg, rx_st_reg;
   reg [3:0] tx_ph_reg, rx_ph_reg;
   reg [2:0] tx_bit_reg, rx_bit_reg;
   reg [7:0] tsr_reg, rsr_reg;
   reg tx_par_reg, tx_line_reg, rx_one_reg;
   reg [10:0] to_reg;
   reg [3:0] irq_id_next;
   wire tick, lp_tick, ir_tx_n, ir_line;

   // frame shape from the adopted settings; infrared overrides it
   wire ir_mode = (SIR_SUPPORT != 0) && a_mctl_reg[`MCTL_IR];
   wire [3:0] dlen = ir_mode ? 4'd8 : {2'b00, a_lctl_reg[1:0]} + 4'd5;
   wire pen = ~ir_mode & a_lctl_reg[`LCTL_PEN];
   wire two_stop = ~ir_mode & a_lctl_reg[`LCTL_STB];
   wire half_stop = two_stop & (a_lctl_reg[1:0] == 2'b00);
   wire [3:0] fbits = 4'd2 + dlen + {3'b000, pen} + {3'b000, two_stop};
   wire [10:0] to_lim = {1'b0, fbits, 6'h00}; // four frames of sixteen ticks per bit
   wire rx_line = ir_mode ? ir_line : serial_rx_in;
   wire rd_rbr = rd_in && addr_in == `A_DATA;
   wire rd_lsr = rd_in && addr_in == `A_LSR;
   wire rd_irq_id = rd_in && addr_in == `A_IID;
   wire wr_thr = wr_in && addr_in == `A_DATA;
   wire rx_done = tick && rx_st_reg == R_STOP && rx_ph_reg == `BIT_TICKS;
   // loading on a tick keeps the start bit a full sixteen ticks
   wire tx_load = tick && tx_st_reg == T_IDLE && ~thr_empty_reg;
   wire [7:0] dmask = 8'hFF >> (4'd8 - dlen);

   baud_gen #(.DW(DW)) u_baud (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .div_in(a_div_reg),
      .lp_div_in(a_lpdiv_reg),
      .tick_out(tick),
      .lp_tick_out(lp_tick),
      .baudout_n_out(baudout_n_out)
   );

   // infrared encoder and decoder exist only when support is built in
   generate
      if (SIR_SUPPORT != 0) begin : g_sir
         sir_codec u_sir (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .tick_in(tick),
            .lp_tick_in(lp_tick),
            .lp_mode_in(a_mctl_reg[`MCTL_LPWR]),
            .tx_active_in(ir_mode && tx_st_reg != T_IDLE),
            .tx_bit_in(tx_line_reg),
            .tx_phase_in(tx_ph_reg),
            .ir_rx_in(ir_rx_in),
            .ir_tx_n_out(ir_tx_n),
            .rx_line_out(ir_line)
         );
      end else begin : g_nosir
         assign ir_tx_n = 1'b1;
         assign ir_line = 1'b1;
      end
   endgenerate

   // software writes to control, divisor and holding registers
   always @(posedge mclk_in) begin
      if (rst_in) begin
         interrupt_enable_reg <= `REG_RST;
         line_control_reg <= `LCTL_RST;
         modem_control_reg <= `REG_RST;
         thr_reg <= `REG_RST;
         div_reg <= `DIV_RST;
         lpdiv_reg <= `DIV_RST;
      end else if (wr_in) begin
         case (addr_in)
            `A_DATA: thr_reg <= wdata_in;
            `A_IEN: interrupt_enable_reg <= wdata_in;
            `A_LCTL: line_control_reg <= wdata_in;
            `A_MCTL: modem_control_reg <= wdata_in;
            `A_DLL: div_reg[7:0] <= wdata_in;
            `A_DIVH: div_reg[15:8] <= wdata_in;
            `A_LPDIVL: lpdiv_reg[7:0] <= wdata_in;
            `A_LPDIVH: lpdiv_reg[15:8] <= wdata_in;
            default: thr_reg <= thr_reg;
         endcase
      end
   end

   // settings reach the serial logic after a fixed settle window
   always @(posedge mclk_in) begin
      if (rst_in) begin
         settle_reg <= 4'h0;
         pend_reg <= 1'b0;
         a_lctl_reg <= `LCTL_RST;
         a_mctl_reg <= `REG_RST;
         a_div_reg <= `DIV_RST;
         a_lpdiv_reg <= `DIV_RST;
      end else if (wr_in && addr_in != `A_DATA && addr_in != `A_IEN) begin
         settle_reg <= `SETTLE_CYC - 4'h2;
         pend_reg <= 1'b1;
      end else if (pend_reg && settle_reg == 4'h0) begin
         pend_reg <= 1'b0;
         a_lctl_reg <= line_control_reg;
         a_mctl_reg <= modem_control_reg;
         a_div_reg <= div_reg;
         a_lpdiv_reg <= lpdiv_reg;
      end else if (pend_reg) begin
         settle_reg <= settle_reg - 4'h1;
      end
   end

   // transmitter: start, data LSB first, parity, stop bits on baud ticks
   always @(posedge mclk_in) begin
      if (rst_in || (pend_reg && settle_reg == 4'h0)) begin
         tx_st_reg <= T_IDLE;
         tx_ph_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
         tsr_reg <= 8'h00;
         tx_par_reg <= 1'b0;
         tx_line_reg <= 1'b1;
      end else if (tx_load) begin
         tx_st_reg <= T_START;
         tx_ph_reg <= 4'h0;
         tsr_reg <= thr_reg & dmask;
         tx_par_reg <= a_lctl_reg[`LCTL_EPS] ~^ (^(thr_reg & dmask));
         tx_line_reg <= 1'b0;
      end else if (tick && tx_st_reg != T_IDLE) begin
         tx_ph_reg <= tx_ph_reg + 4'h1;
         if (tx_ph_reg == `BIT_TICKS ||
             (tx_st_reg == T_STOP2 && half_stop && tx_ph_reg == `HALF_STOP)) begin
            tx_ph_reg <= 4'h0;
            case (tx_st_reg)
               T_START: begin
                  tx_st_reg <= T_DATA;
                  tx_bit_reg <= 3'h0;
                  tx_line_reg <= tsr_reg[0];
               end
               T_DATA: begin
                  if ({1'b0, tx_bit_reg} == dlen - 4'd1) begin
                     tx_st_reg <= pen ? T_PAR : T_STOP;
                     tx_line_reg <= pen ? tx_par_reg : 1'b1;
                  end else begin
                     tx_bit_reg <= tx_bit_reg + 3'h1;
                     tx_line_reg <= tsr_reg[tx_bit_reg + 3'h1];
                  end
               end
               T_PAR: begin
                  tx_st_reg <= T_STOP;
                  tx_line_reg <= 1'b1;
               end
               T_STOP: tx_st_reg <= two_stop ? T_STOP2 : T_IDLE;
               default: tx_st_reg <= T_IDLE;
            endcase
         end
      end
   end

   // serial pins: infrared mode parks the normal output high
   always @(posedge mclk_in) begin
      if (rst_in) begin
         serial_tx_out <= 1'b1;
         ir_tx_n_out <= 1'b1;
      end else begin
         serial_tx_out <= ir_mode | (tx_line_reg & ~a_lctl_reg[`LCTL_BRK]);
         ir_tx_n_out <= ir_tx_n;
      end
   end

   // receiver: qualify start at mid-bit then sample every sixteen ticks
   always @(posedge mclk_in) begin
      if (rst_in || (pend_reg && settle_reg == 4'h0)) begin
         rx_st_reg <= R_IDLE;
         rx_ph_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
         rsr_reg <= 8'h00;
         rx_one_reg <= 1'b0;
      end else if (tick) begin
         rx_ph_reg <= rx_ph_reg + 4'h1;
         case (rx_st_reg)
            R_IDLE: begin
               rx_ph_reg <= 4'h0;
               rsr_reg <= 8'h00;
               rx_one_reg <= 1'b0;
               if (!rx_line) rx_st_reg <= R_START;
            end
            R_START: begin
               if (rx_ph_reg == `MID_TICKS) begin
                  rx_ph_reg <= 4'h0;
                  rx_bit_reg <= 3'h0;
                  rx_st_reg <= rx_line ? R_IDLE : R_DATA;
               end
            end
            R_DATA: begin
               if (rx_ph_reg == `BIT_TICKS) begin
                  rsr_reg[rx_bit_reg] <= rx_line;
                  rx_one_reg <= rx_one_reg | rx_line;
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if ({1'b0, rx_bit_reg} == dlen - 4'd1) rx_st_reg <= pen ? R_PAR : R_STOP;
               end
            end
            R_PAR: begin
               if (rx_ph_reg == `BIT_TICKS) begin
                  rx_st_reg <= R_STOP;
                  rx_one_reg <= rx_one_reg | rx_line;
               end
            end
            R_STOP: begin
               if (rx_ph_reg == `BIT_TICKS) rx_st_reg <= R_IDLE;
            end
            default: rx_st_reg <= R_IDLE;
         endcase
      end
   end

   // receive status flags; a hardware set wins over a software clear
   always @(posedge mclk_in) begin
      if (rst_in) begin
         rbr_reg <= 8'h00;
         dr_reg <= 1'b0;
         oe_reg <= 1'b0;
         pe_reg <= 1'b0;
         fe_reg <= 1'b0;
         bi_reg <= 1'b0;
      end else begin
         if (rd_rbr) dr_reg <= 1'b0;
         if (rd_lsr) begin
            oe_reg <= 1'b0;
            pe_reg <= 1'b0;
            fe_reg <= 1'b0;
            bi_reg <= 1'b0;
         end
         if (tick && rx_st_reg == R_PAR && rx_ph_reg == `BIT_TICKS) begin
            if (rx_line != (a_lctl_reg[`LCTL_EPS] ~^ (^rsr_reg))) pe_reg <= 1'b1;
         end
         if (rx_done) begin
            rbr_reg <= rsr_reg;
            dr_reg <= 1'b1;
            if (dr_reg && !rd_rbr) oe_reg <= 1'b1;
            if (!rx_line) fe_reg <= 1'b1;
            if (!rx_line && !rx_one_reg) bi_reg <= 1'b1;
         end
      end
   end

   // character timeout counts idle ticks while data waits unread
   always @(posedge mclk_in) begin
      if (rst_in) begin
         to_reg <= 11'h000;
         cto_reg <= 1'b0;
      end else begin
         if (!dr_reg || rx_done || rd_rbr || rx_st_reg != R_IDLE) begin
            to_reg <= 11'h000;
         end else if (tick && to_reg != to_lim) begin
            to_reg <= to_reg + 11'h001;
         end
         if (rd_rbr) begin
            cto_reg <= 1'b0;
         end else if (dr_reg && to_reg == to_lim) begin
            cto_reg <= 1'b1;
         end
      end
   end

   // holding register empty flag and its interrupt source
   always @(posedge mclk_in) begin
      if (rst_in) begin
         thr_empty_reg <= 1'b1;
         thre_int_reg <= 1'b1;
      end else begin
         if (tx_load) begin
            thr_empty_reg <= 1'b1;
            thre_int_reg <= 1'b1;
         end else if (wr_thr || (rd_irq_id && irq_id_next == `IID_THRE)) begin
            thre_int_reg <= 1'b0;
         end
         if (wr_thr) begin
            thr_empty_reg <= 1'b0;
            thre_int_reg <= 1'b0;
         end
      end
   end

   // prioritized interrupt identification
   always @* begin
      if (interrupt_enable_reg[`IEN_LINE] && (oe_reg | pe_reg | fe_reg | bi_reg)) begin
         irq_id_next = `IID_LINE;
      end else if (interrupt_enable_reg[`IEN_RDA] && dr_reg) begin
         irq_id_next = `IID_RDA;
      end else if (interrupt_enable_reg[`IEN_RDA] && cto_reg) begin
         irq_id_next = `IID_CTO;
      end else if (interrupt_enable_reg[`IEN_THRE] && thre_int_reg) begin
         irq_id_next = `IID_THRE;
      end else begin
         irq_id_next = `IID_NONE;
      end
   end

   // read data one cycle after the strobe, interrupt line from enabled sources
   always @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
         int_out <= 1'b0;
      end else begin
         int_out <= irq_id_next != `IID_NONE;
         if (rd_in) begin
            case (addr_in)
               `A_DATA: rdata_out <= rbr_reg;
               `A_IEN: rdata_out <= interrupt_enable_reg;
               `A_IID: rdata_out <= {4'h0, irq_id_next};
               `A_LCTL: rdata_out <= line_control_reg;
               `A_MCTL: rdata_out <= modem_control_reg;
               `A_LSR: rdata_out <= {1'b0, thr_empty_reg && tx_st_reg == T_IDLE,
                                     thr_empty_reg, bi_reg, fe_reg, pe_reg, oe_reg, dr_reg};
               `A_DLL: rdata_out <= div_reg[7:0];
               `A_DIVH: rdata_out <= div_reg[15:8];
               `A_LPDIVL: rdata_out <= lpdiv_reg[7:0];
               `A_LPDIVH: rdata_out <= lpdiv_reg[15:8];
               default: rdata_out <= 8'h00;
            endcase
         end
      end
   end
endmodule // uart_core

/* testbench/uart_core_props.sv */
`include "uart_consts.vh"
module uart_core_props (
   input wire mclk_in,
   input wire rst_in,
   input wire [3:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] rdata_out,
   input wire serial_rx_in,
   input wire serial_tx_out,
   input wire ir_rx_in,
   input wire ir_tx_n_out,
   input wire baudout_n_out,
   input wire int_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lctl_q, mctl_q, ien_q;
   logic [15:0] div_q, lo_cnt;
   logic [3:0] wait_cnt;
   wire logic settled = wait_cnt == 4'h0;
   wire logic cfg_wr = wr_in && (addr_in == `A_LCTL || addr_in == `A_MCTL || addr_in >= `A_DLL);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // copies of the written settings, plus a margin past the adoption window
   always @(posedge mclk_in) begin
      if (rst_in) begin
         lctl_q <= `LCTL_RST;
         mctl_q <= 8'h00;
         ien_q <= 8'h00;
         div_q <= 16'h0000;
         wait_cnt <= 4'hC;
      end else begin
         if (wr_in && addr_in == `A_LCTL) lctl_q <= wdata_in;
         if (wr_in && addr_in == `A_MCTL) mctl_q <= wdata_in;
         if (wr_in && addr_in == `A_IEN) ien_q <= wdata_in;
         if (wr_in && addr_in == `A_DLL) div_q[7:0] <= wdata_in;
         if (wr_in && addr_in == `A_DIVH) div_q[15:8] <= wdata_in;
         wait_cnt <= cfg_wr ? 4'hC : (settled ? 4'h0 : wait_cnt - 4'h1);
      end
   end
   // length of the current infrared low pulse
   always @(posedge mclk_in) lo_cnt <= (rst_in || ir_tx_n_out) ? 16'h0000 : lo_cnt + 16'h1;
   sequence lsr_twice;
      rd_in && addr_in == `A_LSR ##2 rd_in && addr_in == `A_LSR;
   endsequence
   sequence tick_gap;
      baudout_n_out ##1 !baudout_n_out;
   endsequence
   ir_serial_high_a: assert property (settled && mctl_q[`MCTL_IR] |-> serial_tx_out)
      else $error("serial output active in infrared mode");
   normal_ir_idle_a: assert property (settled && !mctl_q[`MCTL_IR] |-> ir_tx_n_out)
      else $error("infrared output active in serial mode");
   ir_pulse_width_a: assert property (settled && $rose(ir_tx_n_out) |-> lo_cnt == div_q * 16'h3)
      else $error("infrared pulse width wrong");
   baud_period_a: assert property (settled && div_q == 16'h2 && !baudout_n_out |=> tick_gap)
      else $error("baud reference period wrong");
   int_masked_a: assert property (ien_q == 8'h00 && $past(ien_q) == 8'h00 |-> !int_out)
      else $error("interrupt with all sources masked");
   int_cause_a: assert property ($rose(int_out) |-> $past(ien_q) != 8'h00)
      else $error("interrupt rose without an enabled source");
   line_ctl_readback_a: assert property (rd_in && addr_in == `A_LCTL |=>
      (rdata_out & 8'h5F) == (lctl_q & 8'h5F))
      else $error("line control readback wrong");
   enable_readback_a: assert property (rd_in && addr_in == `A_IEN |=> rdata_out[2:0] == ien_q[2:0])
      else $error("interrupt enable readback wrong");
   status_clear_a: assert property (lsr_twice |=> rdata_out[4:1] == 4'h0)
      else $error("line status errors not cleared by read");
endmodule // uart_core_props
bind uart_core uart_core_props u_props (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .serial_rx_in, .serial_tx_out, .ir_rx_in, .ir_tx_n_out, .baudout_n_out, .int_out);

/* testbench/serial_peer.sv */
module serial_peer (
   input wire logic mclk_in,
   input wire logic tx_in,
   input wire logic ir_tx_n_in,
   output logic rx_out,
   output logic ir_rx_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hung = 1'b0;
   logic ir_sel = 1'b0;
   int cyc = 0;
   wire logic ln = ir_sel ? ir_tx_n_in : tx_in;
   // both lines rest high, as with a pull-up
   initial begin
      rx_out = 1'b1;
      ir_rx_out = 1'b1;
   end
   always @(posedge mclk_in) cyc <= cyc + 1;
   // sends 8 data bits; never while receiving, one direction at a time
   task automatic send(input logic [7:0] d, input int par, input logic stp, input int bt,
         input logic ir);
      logic [11:0] f;
      int k;
      f = 12'hFFF;
      f[0] = 1'b0;
      for (k = 1; k <= 8; k++) f[k] = d[k-1];
      if (par != 0) begin
         f[k] = ^d ^ (par == 2);
         k++;
      end
      f[k] = stp;
      for (int i = 0; i <= k; i++) begin
         if (ir) ir_rx_out <= f[i];
         else rx_out <= f[i];
         // a low stop is cut short past its sample so no false start follows
         repeat (ir ? bt * 3 / 16 : (i == k && !stp) ? bt * 3 / 4 : bt) @(posedge mclk_in);
         ir_rx_out <= 1'b1;
         if (ir) repeat (bt - bt * 3 / 16) @(posedge mclk_in);
      end
      rx_out <= 1'b1;
   endtask
   // waits for a start, then takes k bits: mid sample, or any pulse in infrared
   task automatic grab(output logic [11:0] b, output int tf, input int k, input int bt,
         input logic ir);
      logic lo;
      b = 12'hFFF;
      ir_sel = ir;
      @(negedge mclk_in);
      for (int c = 0; c < 50000 && ln; c++) @(negedge mclk_in);
      if (ln) hung = 1'b1;
      tf = cyc;
      for (int i = 0; i < k; i++) begin
         lo = 1'b0;
         for (int c = 0; c < bt; c++) begin
            if (c == bt / 2) b[i] = ln;
            lo |= !ln;
            @(negedge mclk_in);
         end
         if (ir) b[i] = !lo;
      end
   endtask
endmodule // serial_peer

/* testbench/uart_irda_sir_serial_core_bench.sv */
`include "uart_consts.vh"
module uart_irda_sir_serial_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in, rst_in, wr_in, rd_in;
   logic [3:0] addr_in;
   logic [7:0] wdata_in, v;
   wire logic [7:0] rdata_out;
   wire logic serial_rx_in, serial_tx_out, ir_rx_in, ir_tx_n_out, baudout_n_out, int_out;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [11:0] b, b2;
   int t1, t2;
   uart_core DUT (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .serial_rx_in, .serial_tx_out, .ir_rx_in, .ir_tx_n_out, .baudout_n_out, .int_out);
   serial_peer peer (.mclk_in, .tx_in(serial_tx_out), .ir_tx_n_in(ir_tx_n_out),
      .rx_out(serial_rx_in), .ir_rx_out(ir_rx_in));
   // one clock serves bus and serial side, so the four to one limit holds
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic hang();
      n_mismatch++;
      summarize();
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      d = rdata_out;
      @(posedge mclk_in);
   endtask
   task automatic settle();
      repeat (12) @(posedge mclk_in);
   endtask
   task automatic int_is(input logic e);
      @(negedge mclk_in);
      check(int_out, e);
      @(posedge mclk_in);
   endtask
   // expected line bits of one character, start first
   function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] l);
      logic [11:0] f;
      int k;
      f = 12'hFFF;
      f[0] = 1'b0;
      for (k = 1; k <= l[1:0] + 5; k++) f[k] = d[k-1];
      if (l[3]) f[k] = ^(d & (8'hFF >> (2'h3 - l[1:0]))) ^ ~l[4];
      return f;
   endfunction
   // reset values, unmapped read, break, then divisor of two
   task automatic t_regs();
      rd(`A_LCTL, v);
      check(v, `LCTL_RST);
      rd(4'hF, v);
      check(v, 8'h00);
      wr(`A_LCTL, 8'h43);
      settle();
      check(serial_tx_out, 1'b0);
      wr(`A_LCTL, `LCTL_RST);
      wr(`A_DLL, 8'h02);
      wr(`A_DIVH, 8'h00);
      settle();
      check(serial_tx_out, 1'b1);
   endtask
   // back-to-back characters in several formats; start-to-start gives frame lengths
   task automatic t_tx();
      logic [7:0] l;
      int k, e;
      for (int j = 0; j < 4; j++) begin
         l = j == 0 ? 8'h1B : j == 1 ? 8'h04 : j == 2 ? 8'h0B : 8'h07;
         k = l[1:0] + 7 + l[3];
         e = (k + l[2]) * 32 - ((l[2] && l[1:0] == 2'h0) ? 16 : 0);
         wr(`A_LCTL, l);
         settle();
         fork
            begin
               wr(`A_DATA, 8'hA5);
               wr(`A_DATA, 8'h5A);
            end
            begin
               peer.grab(b, t1, k, 32, 1'b0);
               peer.grab(b2, t2, 1, 32, 1'b0);
            end
         join
         if (peer.hung) hang();
         check(b, frame(8'hA5, l));
         check(t2 - t1 >= e && t2 - t1 <= e + 3, 1'b1);
      end
   endtask
   // good, bad parity, low stop, then a good one with interrupts masked
   task automatic t_rx();
      wr(`A_LCTL, 8'h1B);
      wr(`A_IEN, 8'h05);
      settle();
      for (int j = 0; j < 4; j++) begin
         peer.send(8'h3C, j == 1 ? 2 : 1, j != 2, 32, 1'b0);
         repeat (4) @(posedge mclk_in);
         int_is(j != 3);
         rd(`A_IID, v);
         check(v, j == 3 ? `IID_NONE : j == 0 ? `IID_RDA : `IID_LINE);
         rd(`A_LSR, v);
         check(v & 8'h1F, j == 1 ? 8'h05 : j == 2 ? 8'h09 : 8'h01);
         rd(`A_LSR, v);
         check(v & 8'h1E, 8'h00);
         rd(`A_DATA, v);
         check(v, 8'h3C);
         int_is(1'b0);
         if (j == 2) wr(`A_IEN, 8'h00);
      end
   endtask
   // infrared: receive with parity set in line control, then transmit
   task automatic t_ir();
      wr(`A_MCTL, 8'h40);
      wr(`A_DLL, 8'h37); // 55 keeps the infrared rate under 115.2 kBd
      settle();
      peer.send(8'h5A, 0, 1'b1, 880, 1'b1);
      repeat (4) @(posedge mclk_in);
      rd(`A_LSR, v);
      check(v & 8'h1F, 8'h01);
      rd(`A_DATA, v);
      check(v, 8'h5A);
      fork
         wr(`A_DATA, 8'h0F);
         peer.grab(b, t1, 10, 880, 1'b1);
      join
      if (peer.hung) hang();
      check(b, frame(8'h0F, 8'h03));
   endtask
   // reset, then the scenarios in turn
   initial begin
      rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      t_regs();
      t_tx();
      t_rx();
      t_ir();
      summarize();
   end
endmodule // uart_irda_sir_serial_core_bench
